// File: design/srw_guard.sv
// Two-wire register target with confirmation guard on protected settings
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Enable bit gates protocol; loaded from OTP
// - Protected write makes random code readable
// - Matching code applies pending write unchanged
// - Mismatching code discards pending write
// - Other write cancels pending, runs normally
// - No confirmation in 10 ms cancels
// - Confirmation needed only while enable is 1
// - System configuration entries are protected
// - Output pin control entries are protected
// - External monitor entries are protected
// - Switching regulator entries are protected
// - Linear and always-on entries are protected
module srw_guard import srw_pkg::*; #(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter logic [6:0] DEVICE_ADDR = DEV_ADDR
) (
    // Core clock and reset
    input wire logic mclk,
    input wire logic reset,
    // One-time-programmable default of protection
    input wire logic otpSecureDefault,
    // Two-wire link, oversampled on its own clock
    input wire logic linkClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // Settings towards the rest of the device
    output logic [NUM_REGS*8-1:0] settings,
    output logic secureEnable,
    output logic confirmPending
);
    // ------------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------------
    // Timer's last value, one short of the full window; the wait ends there and the timer clears
    localparam logic [TIMER_W-1:0] TO_LAST = TIMER_W'(TIMEOUT_CYCLES - 1);

    // Address falls inside the settings bank
    function automatic logic inBank(input logic [7:0] a);
        inBank = (a < 8'(NUM_REGS));
    endfunction

    // Address needs confirmation while protection is on
    function automatic logic isProt(input logic [7:0] a);
        isProt = (inBank(a) && PROT_MASK[a[IDX_W-1:0]]) || (a == ADDR_CTRL);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    srw_core_t c;      // Core domain state
    srw_core_t n;      // Core next value
    srw_link_t l;      // Link domain state
    srw_link_t m;      // Link next value
    logic [2:0] rstSync;  // Reset carried into link domain
    logic linkRst;
    // Core helpers
    logic evt;         // New request seen from link
    srw_xfer_t x;      // Request word, stable once toggle seen
    logic [IDX_W-1:0] reqIdx;
    logic [IDX_W-1:0] pendIdx;
    logic apEn;        // Apply a write this cycle
    logic [7:0] apAddr;
    logic [7:0] apData;
    logic [7:0] ctrlVal;
    // Link helpers
    logic sclNew;
    logic sdaNew;
    logic rise;
    logic fall;
    logic startC;
    logic stopC;
    logic rspEvt;

    assign x = l.req;
    assign reqIdx = x.addr[IDX_W-1:0];
    assign pendIdx = c.pendAddr[IDX_W-1:0];
    // Toggle counts once second and third stage agree
    assign evt = (c.reqSync[1] == c.reqSync[2]) && (c.reqSync[2] != c.reqLvl);
    assign linkRst = rstSync[2];

    // ------------------------------------------------------------------
    // Core domain: guard and settings bank
    // ------------------------------------------------------------------
    // Next state of the guard
    always_comb begin
        n = c;
        apEn = 1'b0;
        apAddr = 8'h00;
        apData = 8'h00;
        ctrlVal = 8'h00;
        ctrlVal[CTRL_SEC_BIT] = c.secEn;
        ctrlVal[CTRL_PEND_BIT] = (c.st == G_AWAIT);
        n.reqSync = {c.reqSync[1:0], l.reqTgl};
        if (c.reqSync[1] == c.reqSync[2]) begin
            n.reqLvl = c.reqSync[2];
        end
        // Free-running code source, so codes are not predictable
        n.lfsr = {c.lfsr[6:0], c.lfsr[7] ^ c.lfsr[5] ^ c.lfsr[4] ^ c.lfsr[3]};
        if (c.st == G_AWAIT) begin
            n.timer = TIMER_W'(c.timer + 1'b1);
        end
        if (evt && x.isWrite) begin
            if (x.addr == ADDR_CODE_CHK) begin
                n.codeChk = x.data;
                if (c.st == G_AWAIT) begin
                    n.st = G_IDLE;
                    n.timer = '0;
                    if (x.data == c.codeSrc) begin
                        apEn = 1'b1;
                        apAddr = c.pendAddr;
                        apData = c.pendData;
                    end
                end
            end else begin
                n.st = G_IDLE;
                n.timer = '0;
                if (c.secEn && isProt(x.addr)) begin
                    n.st = G_AWAIT;
                    n.pendAddr = x.addr;
                    n.pendData = x.data;
                    n.codeSrc = c.lfsr;
                end else begin
                    apEn = 1'b1;
                    apAddr = x.addr;
                    apData = x.data;
                end
            end
        end else if (evt) begin
            // Reads never disturb a pending write
            unique case (x.addr)
                ADDR_CODE_SRC: n.rspData = c.codeSrc;
                ADDR_CODE_CHK: n.rspData = c.codeChk;
                ADDR_CTRL: n.rspData = ctrlVal;
                default: n.rspData = inBank(x.addr) ? c.bank[reqIdx] : 8'h00;
            endcase
            n.rspTgl = ~c.rspTgl;
        end
        // Expiry is checked apart from the request chain, so a read that
        // lands on the last cycle cannot push the timer past its limit
        // confirmation window expired
        if (!(evt && x.isWrite) && c.st == G_AWAIT && c.timer == TO_LAST) begin
            n.st = G_IDLE;
            n.timer = '0;
        end
        // Single write port into bank and control
        if (apEn) begin
            if (inBank(apAddr)) begin
                n.bank[apAddr[IDX_W-1:0]] = apData;
            end else if (apAddr == ADDR_CTRL) begin
                n.secEn = apData[CTRL_SEC_BIT];
            end
        end
        if (reset) begin
            n = '0;
            n.st = G_IDLE;
            n.lfsr = LFSR_SEED;
            n.bank = {NUM_REGS{REG_RST}};
            n.secEn = otpSecureDefault;
        end
    end

    // Core register
    always_ff @(posedge mclk) begin
        c <= n;
    end

    assign settings = c.bank;
    assign secureEnable = c.secEn;
    assign confirmPending = (c.st == G_AWAIT);

    // ------------------------------------------------------------------
    // Link domain: bit engine
    // ------------------------------------------------------------------
    // Reset synchroniser into link clock
    always_ff @(posedge linkClk) begin
        rstSync <= {rstSync[1:0], reset};
    end

    // Next state of the link engine
    always_comb begin
        m = l;
        m.sclS = {l.sclS[1:0], sclIn};
        m.sdaS = {l.sdaS[1:0], sdaIn};
        m.rspSync = {l.rspSync[1:0], c.rspTgl};
        // Glitch filter: level moves once stages two and three agree
        sclNew = (l.sclS[1] == l.sclS[2]) ? l.sclS[2] : l.sclF;
        sdaNew = (l.sdaS[1] == l.sdaS[2]) ? l.sdaS[2] : l.sdaF;
        m.sclF = sclNew;
        m.sdaF = sdaNew;
        rise = sclNew & ~l.sclF;
        fall = ~sclNew & l.sclF;
        startC = l.sclF & sclNew & l.sdaF & ~sdaNew;
        stopC = l.sclF & sclNew & ~l.sdaF & sdaNew;
        rspEvt = (l.rspSync[1] == l.rspSync[2]) && (l.rspSync[2] != l.rspLvl);
        if (l.rspSync[1] == l.rspSync[2]) begin
            m.rspLvl = l.rspSync[2];
        end
        // Read data word is stable while its toggle crosses
        if (rspEvt) begin
            m.rdData = c.rspData;
        end
        if (startC) begin
            m.st = L_ADDR;
            m.cnt = 4'h0;
            m.oeN = 1'b1;
        end else if (stopC) begin
            m.st = L_IDLE;
            m.oeN = 1'b1;
        end else if (rise) begin
            unique case (l.st)
                L_ADDR, L_REG, L_WDATA: begin
                    m.sh = {l.sh[6:0], sdaNew};
                    m.cnt = l.cnt + 4'h1;
                end
                L_RDATA: m.cnt = l.cnt + 4'h1;
                L_RDATA_ACK: m.nack = sdaNew;
                default: m.cnt = l.cnt;
            endcase
        end else if (fall) begin
            unique case (l.st)
                L_ADDR: begin
                    if (l.cnt == 4'h8 && l.sh[7:1] == DEVICE_ADDR) begin
                        m.st = L_ADDR_ACK;
                        m.rw = l.sh[0];
                        m.oeN = 1'b0;
                    end else if (l.cnt == 4'h8) begin
                        m.st = L_IDLE;
                    end
                end
                L_ADDR_ACK, L_RDATA_ACK: begin
                    if (l.st == L_ADDR_ACK ? l.rw : ~l.nack) begin
                        // Load prefetched byte, prefetch the next
                        m.st = L_RDATA;
                        m.sh = l.rdData;
                        m.oeN = l.rdData[7];
                        m.cnt = 4'h0;
                        m.ptr = l.ptr + 8'h01;
                        m.req = '{isWrite: 1'b0, addr: l.ptr + 8'h01, data: 8'h00};
                        m.reqTgl = ~l.reqTgl;
                    end else begin
                        m.st = (l.st == L_ADDR_ACK) ? L_REG : L_IDLE;
                        m.cnt = 4'h0;
                        m.oeN = 1'b1;
                    end
                end
                L_REG: begin
                    if (l.cnt == 4'h8) begin
                        m.st = L_REG_ACK;
                        m.ptr = l.sh;
                        m.oeN = 1'b0;
                        m.req = '{isWrite: 1'b0, addr: l.sh, data: 8'h00};
                        m.reqTgl = ~l.reqTgl;
                    end
                end
                L_REG_ACK, L_WDATA_ACK: begin
                    m.st = L_WDATA;
                    m.cnt = 4'h0;
                    m.oeN = 1'b1;
                end
                L_WDATA: begin
                    // Write taken only after the eighth bit
                    if (l.cnt == 4'h8) begin
                        m.st = L_WDATA_ACK;
                        m.oeN = 1'b0;
                        m.req = '{isWrite: 1'b1, addr: l.ptr, data: l.sh};
                        m.reqTgl = ~l.reqTgl;
                        m.ptr = l.ptr + 8'h01;
                    end
                end
                L_RDATA: begin
                    if (l.cnt == 4'h8) begin
                        m.st = L_RDATA_ACK;
                        m.oeN = 1'b1;
                    end else begin
                        m.sh = {l.sh[6:0], 1'b0};
                        m.oeN = l.sh[6];
                    end
                end
                default: m.st = L_IDLE;
            endcase
        end
        if (linkRst) begin
            m = '0;
            m.st = L_IDLE;
            m.sclS = 3'h7;
            m.sdaS = 3'h7;
            m.sclF = 1'b1;
            m.sdaF = 1'b1;
            m.oeN = 1'b1;
        end
    end

    // Link register
    always_ff @(posedge linkClk) begin
        l <= m;
    end

    // Open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOeN = l.oeN;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_PEND_HOLD: assert property (evt && x.isWrite && c.secEn && isProt(x.addr) |=>
        c.bank == $past(c.bank) && c.secEn) else $error("protected write applied early");
    AST_OTP_LOAD: assert property ($fell(reset) |->
        c.secEn == $past(otpSecureDefault)) else $error("enable not loaded from OTP");
    AST_CODE_GEN: assert property (evt && x.isWrite && c.secEn && isProt(x.addr) |=>
        c.st == G_AWAIT && c.codeSrc == $past(c.lfsr)) else $error("code not generated");
    AST_APPLY: assert property (c.st == G_AWAIT && evt && x.isWrite && x.addr == ADDR_CODE_CHK &&
        x.data == c.codeSrc && inBank(c.pendAddr) |=> c.bank[$past(pendIdx)] == $past(c.pendData))
        else $error("confirmed write not applied");
    AST_MISMATCH: assert property (c.st == G_AWAIT && evt && x.isWrite && x.addr == ADDR_CODE_CHK &&
        x.data != c.codeSrc |=> c.st == G_IDLE && c.bank == $past(c.bank) && c.secEn == $past(c.secEn))
        else $error("mismatch changed settings");
    AST_OTHER: assert property (c.st == G_AWAIT && evt && x.isWrite && x.addr != ADDR_CODE_CHK &&
        !isProt(x.addr) && inBank(x.addr) |=> c.st == G_IDLE && c.bank[$past(reqIdx)] == $past(x.data))
        else $error("other command not run");
    AST_TIMEOUT: assert property (c.st == G_AWAIT && !evt && c.timer == TO_LAST |=>
        c.st == G_IDLE) else $error("pending write outlived window");
    AST_TIMER_BOUND: assert property (c.st == G_AWAIT |-> c.timer <= TO_LAST)
        else $error("timer beyond window");
    AST_DISABLED: assert property (!c.secEn && evt && x.isWrite && inBank(x.addr) |=>
        c.bank[$past(reqIdx)] == $past(x.data) && c.st == G_IDLE) else $error("unprotected write lost");

    COV_CONFIRM: cover property (c.st == G_AWAIT && evt && x.isWrite && x.addr == ADDR_CODE_CHK &&
        x.data == c.codeSrc);
    COV_MISMATCH: cover property (c.st == G_AWAIT && evt && x.isWrite && x.addr == ADDR_CODE_CHK &&
        x.data != c.codeSrc);
    COV_TIMEOUT: cover property (c.st == G_AWAIT ##1 c.st == G_IDLE && !$past(evt));
    COV_CANCEL: cover property (c.st == G_AWAIT && evt && x.isWrite && x.addr != ADDR_CODE_CHK);
endmodule

`default_nettype wire

// File: design/srw_pkg.sv
// Constants, carriers and state types of the secure register write guard
package srw_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int NUM_REGS = 16;
    localparam int IDX_W = 4;
    localparam logic [7:0] ADDR_CODE_SRC = 8'h10;
    localparam logic [7:0] ADDR_CODE_CHK = 8'h11;
    localparam logic [7:0] ADDR_CTRL = 8'h12;
    // Bank entries that need confirmation while protection is on
    localparam logic [NUM_REGS-1:0] PROT_MASK = 16'h0FFF;
    // Control register fields
    localparam int CTRL_SEC_BIT = 0;
    localparam int CTRL_PEND_BIT = 1;
    // Values after reset
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] LFSR_SEED = 8'hA5;
    localparam logic [6:0] DEV_ADDR = 7'h08;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_MS = 10;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int TIMER_W = 20;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic isWrite;
        logic [7:0] addr;
        logic [7:0] data;
    } srw_xfer_t;
    typedef enum logic {
        G_IDLE = 1'b0,
        G_AWAIT = 1'b1
    } srw_guard_st_t;
    typedef enum logic [3:0] {
        L_IDLE = 4'h0,
        L_ADDR = 4'h1,
        L_ADDR_ACK = 4'h2,
        L_REG = 4'h3,
        L_REG_ACK = 4'h4,
        L_WDATA = 4'h5,
        L_WDATA_ACK = 4'h6,
        L_RDATA = 4'h7,
        L_RDATA_ACK = 4'h8
    } srw_link_st_t;
    typedef struct packed {
        srw_guard_st_t st;
        logic secEn;
        logic [7:0] lfsr;
        logic [7:0] codeSrc;
        logic [7:0] codeChk;
        logic [7:0] pendAddr;
        logic [7:0] pendData;
        logic [TIMER_W-1:0] timer;
        logic [NUM_REGS-1:0][7:0] bank;
        logic [2:0] reqSync;
        logic reqLvl;
        logic [7:0] rspData;
        logic rspTgl;
    } srw_core_t;
    typedef struct packed {
        srw_link_st_t st;
        logic [2:0] sclS;
        logic [2:0] sdaS;
        logic sclF;
        logic sdaF;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic oeN;
        srw_xfer_t req;
        logic reqTgl;
        logic [2:0] rspSync;
        logic rspLvl;
        logic [7:0] rdData;
    } srw_link_t;
endpackage

// File: bench/srw_host.sv
// Behavioural two-wire bus controller standing opposite the guard
`timescale 1ns/1ns
`default_nettype none

module srw_host import srw_pkg::*; #(
    // Half bit time in core cycles; 660 ns keeps above the link filter limit
    parameter int HALF = 66
) (
    // Core clock paces the bus timing
    input wire logic mclk,
    // Device pull-down enable, active low
    input wire logic sdaOeN,
    // Resolved wire levels towards the device
    output logic sclIn,
    output logic sdaIn
);
    // ------------------------------------------------------------------
    // Wire levels
    // ------------------------------------------------------------------
    // Released lines read high through the pull-ups
    logic sclDrv = 1'b1;
    logic sdaDrv = 1'b1;
    // Clock stands high between frames
    assign sclIn = sclDrv;
    // Open drain: whichever party pulls low wins
    assign sdaIn = sdaDrv & sdaOeN;

    // ------------------------------------------------------------------
    // Bus cycle tasks
    // ------------------------------------------------------------------
    // Wait a number of core cycles
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One bit out, level seen mid high phase back
    task automatic bitIo(input logic b, output logic r);
        tick(HALF / 2);
        sdaDrv <= b;
        tick(HALF / 2);
        sclDrv <= 1'b1;
        tick(HALF / 2);
        r = sdaIn;
        tick(HALF / 2);
        sclDrv <= 1'b0;
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic byteIo(input logic [7:0] b, input logic ackIn, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitIo(b[i], r[i]);
        end
        bitIo(ackIn, ack);
    endtask

    // Start, also used as repeated start
    task automatic frameStart();
        tick(HALF / 2);
        sdaDrv <= 1'b1;
        tick(HALF / 2);
        sclDrv <= 1'b1;
        tick(HALF);
        sdaDrv <= 1'b0;
        tick(HALF);
        sclDrv <= 1'b0;
    endtask

    // Stop leaves both lines released
    task automatic frameStop();
        tick(HALF / 2);
        sdaDrv <= 1'b0;
        tick(HALF / 2);
        sclDrv <= 1'b1;
        tick(HALF);
        sdaDrv <= 1'b1;
        tick(HALF);
    endtask

    // plain write frame, protected or not
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2;
        frameStart();
        byteIo({DEV_ADDR, 1'b0}, 1'b1, r, k0);
        byteIo(a, 1'b1, r, k1);
        byteIo(d, 1'b1, r, k2);
        frameStop();
        ok = !(k0 | k1 | k2);
    endtask

    // Pointer phase, repeated start, one byte closed by a refusal
    task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, kn;
        frameStart();
        byteIo({DEV_ADDR, 1'b0}, 1'b1, r, k0);
        byteIo(a, 1'b1, r, k1);
        frameStart();
        byteIo({DEV_ADDR, 1'b1}, 1'b1, r, k2);
        byteIo(8'hFF, 1'b1, d, kn);
        frameStop();
        ok = !(k0 | k1 | k2);
    endtask
endmodule

`default_nettype wire

// File: bench/srw_guard_tb.sv
// Self-checking bench for the secure register write guard
`timescale 1ns/1ns
`default_nettype none

module srw_guard_tb import srw_pkg::*;;
    // Shortened confirmation window, still longer than a read plus a write
    localparam int TMO = 12000;
    // Core side stimulus
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic otpSecureDefault = 1'b1;
    logic linkClk;
    // Link wires and device outputs
    logic sclIn, sdaIn, sdaOut, sdaOeN;
    logic [NUM_REGS*8-1:0] settings;
    logic secureEnable, confirmPending;
    int badCount = 0;
    int nCompared = 0;

    // ------------------------------------------------------------------
    // Clocks and instances
    // ------------------------------------------------------------------
    always #5 mclk = ~mclk;
    // Link clock offset so its edges never line up with the core clock
    initial begin
        linkClk = 1'b0;
        #7;
        forever #40 linkClk = ~linkClk;
    end
    srw_guard #(.TIMEOUT_CYCLES(TMO)) srw_guard_i (.mclk(mclk), .reset(reset),
        .otpSecureDefault(otpSecureDefault), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .settings(settings), .secureEnable(secureEnable),
        .confirmPending(confirmPending));
    srw_host srw_host_i (.mclk(mclk), .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] setByte(input int i);
        return settings[8*i +: 8];
    endfunction
    // Write frame, acknowledge checked, outputs allowed to settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        srw_host_i.writeReg(a, d, ok);
        check("write ack", {7'h00, ok}, 8'h01);
        tick(20);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic ok;
        srw_host_i.readReg(a, d, ok);
        check("read ack", {7'h00, ok}, 8'h01);
        tick(20);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] v;
        check("bank any set", {7'h00, |settings}, 8'h00);
        check("enable", {7'h00, secureEnable}, 8'h01);
        check("pending", {7'h00, confirmPending}, 8'h00);
        check("sda out", {7'h00, sdaOut}, 8'h00);
        rd(ADDR_CTRL, v);
        check("control", v, 8'h01);
        rd(ADDR_CODE_CHK, v);
        check("code check", v, 8'h00);
        $display("test reset done");
    endtask
    // Lowest protected entry, full confirmation
    task automatic t_confirm();
        logic [7:0] c;
        wr(8'h00, 8'h5A);
        check("pending", {7'h00, confirmPending}, 8'h01);
        check("held byte", setByte(0), 8'h00);
        rd(ADDR_CODE_SRC, c);
        check("zero code", {7'h00, c == 8'h00}, 8'h00);
        check("pending after read", {7'h00, confirmPending}, 8'h01);
        wr(ADDR_CODE_CHK, c);
        check("applied", setByte(0), 8'h5A);
        check("pending", {7'h00, confirmPending}, 8'h00);
        $display("test confirm done");
    endtask
    task automatic t_mismatch();
        logic [7:0] c;
        wr(8'h05, 8'h3C);
        rd(ADDR_CODE_SRC, c);
        wr(ADDR_CODE_CHK, ~c);
        check("discarded", setByte(5), 8'h00);
        check("pending", {7'h00, confirmPending}, 8'h00);
        $display("test mismatch done");
    endtask
    // Last protected entry cancelled by first unprotected one
    task automatic t_other();
        wr(8'h0B, 8'h11);
        check("pending", {7'h00, confirmPending}, 8'h01);
        wr(8'h0C, 8'h77);
        check("pending", {7'h00, confirmPending}, 8'h00);
        check("abandoned", setByte(11), 8'h00);
        check("new command", setByte(12), 8'h77);
        $display("test other done");
    endtask
    task automatic t_timeout();
        int n;
        wr(8'h02, 8'h44);
        n = 0;
        while (confirmPending === 1'b1 && n < TMO + 2000) begin
            tick(1);
            n++;
        end
        check("early cancel", {7'h00, n < TMO - 1500}, 8'h00);
        check("pending", {7'h00, confirmPending}, 8'h00);
        check("cancelled", setByte(2), 8'h00);
        if (confirmPending !== 1'b0) begin
            wrap_up();
        end
        $display("test timeout done");
    endtask
    // Enable bit guards itself, then off means direct writes
    task automatic t_disable();
        logic [7:0] c;
        wr(ADDR_CTRL, 8'h00);
        check("enable held", {7'h00, secureEnable}, 8'h01);
        rd(ADDR_CODE_SRC, c);
        wr(ADDR_CODE_CHK, c);
        check("enable", {7'h00, secureEnable}, 8'h00);
        wr(8'h04, 8'h99);
        check("pending", {7'h00, confirmPending}, 8'h00);
        check("direct", setByte(4), 8'h99);
        $display("test disable done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    // Reset spans several link clocks so the link side clears too
    initial begin
        tick(40);
        reset <= 1'b0;
        tick(60);
        t_reset();
        t_confirm();
        t_mismatch();
        t_other();
        t_timeout();
        t_disable();
        wrap_up();
    end
endmodule

`default_nettype wire
